// ---- logic/sei_map.svh ----
// Constants for the serial error and interrupt block
`ifndef SEI_MAP_SVH
`define SEI_MAP_SVH
`define SEI_BYTE_W 8
`define SEI_BIT_CNT_W 4
`define SEI_BITS_PER_BYTE 4'h8
`define SEI_OVR_BIT_IDX 4'h7
`define SEI_FIFO_DEPTH 4
`endif

// ---- logic/sei_pkg.sv ----
// Types for the serial error and interrupt block
package sei_pkg;
  typedef enum logic [1:0] {
    SEI_IDLE,
    SEI_ACTIVE,
    SEI_TAIL
  } sei_xfer_t;
endpackage : sei_pkg

// ---- logic/sei_fifo.sv ----
// Small FIFO for received bytes
`timescale 1ns/1ns
`default_nettype none
module sei_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sei_fifo
`default_nettype wire

// ---- logic/sei_core.sv ----
// Serial error detection and interrupt request logic
// Summary of operation
// - Overflow sets when received data unread at bit-1 capture of next byte.
// - On overflow the new byte is dropped; old unread byte stays readable.
// - Error enable gates overflow and mode fault together onto one request.
// - Mode fault sets only with its enable; clearing enable keeps flag.
// - Master with mode fault enable: select low sets mode fault.
// - Master fault: module off, tx empty set, counter cleared, pins released.
// - Mode fault never changes master select.
// - Slave: select rising during transfer sets mode fault.
// - Phase 0: transfer starts at select fall, ends idle after bit eight.
// - Phase 1: starts at clock leaving idle with select low.
// - Phase 0 select/deselect without clocks faults; phase 1 does not.
// - Slave fault raises error request, leaves module enable and state alone.
// - Deselected slave floats its data output and ignores clock edges.
// - Mode fault clears by status read then control write, without fault.
// - Tx enable lets tx empty drive transmitter request.
// - Rx enable lets receiver full drive receiver request only when enabled.
// - Receiver full sets on each byte moved into receive data.
// - Tx empty sets on each byte moved from transmit data to shifter.
// - Receiver full, mode fault and overflow share one vector.
// - Overflow and mode fault requests need error enable only; fault enable gates the flag.
`timescale 1ns/1ns
`default_nettype none
`include "sei_map.svh"
module sei_core
  import sei_pkg::*;
#(
  parameter int BYTE_W = `SEI_BYTE_W,
  parameter int FIFO_DEPTH = `SEI_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic module_enable_set,
  input wire logic module_enable_clr,
  input wire logic master_select,
  input wire logic clock_phase,
  input wire logic clock_polarity,
  input wire logic mode_fault_enable,
  input wire logic error_irq_enable,
  input wire logic tx_irq_enable,
  input wire logic rx_irq_enable,
  input wire logic status_read,
  input wire logic control_write,
  input wire logic data_read,
  input wire logic data_write,
  input wire logic [BYTE_W-1:0] tx_data,
  input wire logic slave_select_n,
  input wire logic serial_clock_pin,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe,
  output logic port_owned,
  output logic module_enable,
  output logic overflow_flag,
  output logic mode_fault_flag,
  output logic receiver_full_flag,
  output logic transmitter_empty_flag,
  output logic [BYTE_W-1:0] rx_data,
  output logic tx_irq,
  output logic rx_err_irq,
  output logic [`SEI_BIT_CNT_W-1:0] bit_count
);
  sei_xfer_t state_ff;
  logic module_enable_ff;
  logic ovr_ff;
  logic mode_fault_flag_ff;
  logic rxf_ff;
  logic txe_ff;
  logic clr_armed_ff;
  logic ss_n_ff;
  logic sck_ff;
  logic [`SEI_BIT_CNT_W-1:0] cnt_ff;
  logic [BYTE_W-1:0] shift_ff;
  logic [BYTE_W-1:0] tx_buf_ff;
  logic [BYTE_W-1:0] rx_data_ff;
  logic miso_ff;
  logic sck_idle;
  logic sck_lead;
  logic sck_trail;
  logic ss_fall;
  logic ss_rise;
  logic slave_sel;
  logic capture;
  logic byte_done;
  logic fault_cond;
  logic master_cond;
  logic slave_cond;
  logic set_mode_fault_flag;
  logic master_fault;
  logic start_xfer;
  logic ovr_event;
  logic rx_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [BYTE_W-1:0] fifo_out_data;
  logic load_rx;

  // Edges of the pins, sampled on core_clk
  assign sck_idle = (serial_clock_pin == clock_polarity);
  assign sck_lead = (sck_ff == clock_polarity) && !sck_idle;
  assign sck_trail = (sck_ff != clock_polarity) && sck_idle;
  assign ss_fall = ss_n_ff && !slave_select_n;
  assign ss_rise = !ss_n_ff && slave_select_n;
  assign slave_sel = module_enable_ff && !master_select && !slave_select_n;
  // Capture on leading edge in phase 0, trailing edge in phase 1
  assign capture = slave_sel && (state_ff == SEI_ACTIVE) && (clock_phase ? sck_trail : sck_lead);
  assign byte_done = capture && (cnt_ff == `SEI_BITS_PER_BYTE - 4'h1);
  assign start_xfer = slave_sel && (state_ff == SEI_IDLE) &&
    (clock_phase ? sck_lead : ss_fall);

  // Fault conditions; phase 1 selected with no clocks is not a transfer
  // Master condition is a level that still blocks the clear after shutdown
  assign master_cond = master_select && !slave_select_n;
  assign slave_cond = !master_select && module_enable_ff && ss_rise &&
    (state_ff != SEI_IDLE);
  assign fault_cond = master_cond || slave_cond;
  assign set_mode_fault_flag = fault_cond && mode_fault_enable && module_enable_ff;
  assign master_fault = set_mode_fault_flag && master_select;

  // Overflow is judged at the bit-1 capture, one before the last bit
  assign ovr_event = capture && (cnt_ff == `SEI_OVR_BIT_IDX - 4'h1) && rxf_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ss_n_ff <= 1'b1;
      // Idle level, so no false clock edge follows reset
      sck_ff <= clock_polarity;
    end else begin
      ss_n_ff <= slave_select_n;
      sck_ff <= serial_clock_pin;
    end
  end

  // Module enable; slave fault leaves it set
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      module_enable_ff <= 1'b0;
    end else if (master_fault || module_enable_clr) begin
      module_enable_ff <= 1'b0;
    end else if (module_enable_set) begin
      module_enable_ff <= 1'b1;
    end
  end

  // Transfer tracker; disable aborts it
  always_ff @(posedge core_clk) begin
    if (sys_rst || !module_enable_ff || master_fault) begin
      state_ff <= SEI_IDLE;
      cnt_ff <= '0;
    end else begin
      case (state_ff)
        SEI_IDLE: begin
          if (start_xfer) begin
            state_ff <= SEI_ACTIVE;
            cnt_ff <= '0;
          end
        end
        SEI_ACTIVE: begin
          if (byte_done) begin
            state_ff <= SEI_TAIL;
          end
          if (capture) begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        SEI_TAIL: begin
          if (sck_idle || slave_select_n) begin
            state_ff <= SEI_IDLE;
          end
        end
        default: state_ff <= SEI_IDLE;
      endcase
    end
  end

  // Shifter and transmit buffer
  always_ff @(posedge core_clk) begin
    if (sys_rst || !module_enable_ff) begin
      shift_ff <= '0;
      tx_buf_ff <= '0;
      txe_ff <= 1'b1;
      miso_ff <= 1'b0;
    end else begin
      if (data_write && txe_ff) begin
        tx_buf_ff <= tx_data;
      end
      // Master fault set wins over a write in the same cycle
      if (master_fault) begin
        txe_ff <= 1'b1;
      end else if (data_write && txe_ff) begin
        txe_ff <= 1'b0;
      end
      if (start_xfer) begin
        shift_ff <= txe_ff ? shift_ff : tx_buf_ff;
        miso_ff <= txe_ff ? shift_ff[BYTE_W-1] : tx_buf_ff[BYTE_W-1];
        if (!txe_ff) begin
          txe_ff <= 1'b1;
        end
      end else if (capture) begin
        shift_ff <= {shift_ff[BYTE_W-2:0], mosi_in};
        miso_ff <= shift_ff[BYTE_W-2];
      end
    end
  end

  // Received bytes queue, dropped on overflow
  assign rx_push = byte_done && !ovr_ff && !ovr_event;
  assign load_rx = fifo_out_valid && !rxf_ff;

  sei_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data({shift_ff[BYTE_W-2:0], mosi_in}),
    .out_valid(fifo_out_valid),
    .out_ready(load_rx),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_data_ff <= '0;
      rxf_ff <= 1'b0;
    end else if (load_rx) begin
      rx_data_ff <= fifo_out_data;
      rxf_ff <= 1'b1;
    end else if (data_read) begin
      rxf_ff <= 1'b0;
    end
  end

  // Overflow clears by status read then data read; set wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ovr_ff <= 1'b0;
    end else if (ovr_event || (byte_done && !fifo_in_ready)) begin
      ovr_ff <= 1'b1;
    end else if (clr_armed_ff && data_read) begin
      ovr_ff <= 1'b0;
    end
  end

  // Clear sequence armed by status read; fault breaks it
  always_ff @(posedge core_clk) begin
    if (sys_rst || fault_cond) begin
      clr_armed_ff <= 1'b0;
    end else if (status_read) begin
      clr_armed_ff <= 1'b1;
    end else if (control_write || data_read) begin
      clr_armed_ff <= 1'b0;
    end
  end

  // Mode fault flag; master_select is an input and untouched
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_fault_flag_ff <= 1'b0;
    end else if (set_mode_fault_flag) begin
      mode_fault_flag_ff <= 1'b1;
    end else if (clr_armed_ff && control_write && !fault_cond) begin
      mode_fault_flag_ff <= 1'b0;
    end
  end

  // Requests; all receive side events share one output
  assign tx_irq = tx_irq_enable && txe_ff;
  assign rx_err_irq = (rx_irq_enable && rxf_ff && module_enable_ff) ||
    (error_irq_enable && (ovr_ff || mode_fault_flag_ff));

  assign miso_out = miso_ff;
  assign miso_oe = slave_sel;
  assign port_owned = module_enable_ff;
  assign module_enable = module_enable_ff;
  assign overflow_flag = ovr_ff;
  assign mode_fault_flag = mode_fault_flag_ff;
  assign receiver_full_flag = rxf_ff;
  assign transmitter_empty_flag = txe_ff;
  assign rx_data = rx_data_ff;
  assign bit_count = cnt_ff;

  chk_master_fault_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    master_fault |=> !module_enable_ff && txe_ff && cnt_ff == '0)
    else $error("master fault did not shut down");
  chk_master_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
    (master_fault && error_irq_enable) |=> (rx_err_irq || !error_irq_enable))
    else $error("master fault request missing");
  chk_mode_fault_flag_needs_en: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(mode_fault_flag_ff) |-> $past(mode_fault_enable))
    else $error("mode fault set without enable");
  chk_mode_fault_flag_blocked: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!mode_fault_enable && !mode_fault_flag_ff) |=> !mode_fault_flag_ff)
    else $error("mode fault set while blocked");
  chk_slave_fault_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    (set_mode_fault_flag && !master_select && !module_enable_clr) |=> module_enable_ff)
    else $error("slave fault cleared enable");
  chk_ovr_keeps_data: assert property (@(posedge core_clk) disable iff (sys_rst)
    ovr_event |-> !rx_push)
    else $error("overflow byte not dropped");
  chk_ovr_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
    ovr_event |=> ovr_ff)
    else $error("overflow not flagged");
  chk_miso_float: assert property (@(posedge core_clk) disable iff (sys_rst)
    slave_select_n |-> !miso_oe && !capture)
    else $error("deselected slave active");
  chk_deselect_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
    (slave_select_n && module_enable_ff && !master_fault && state_ff == SEI_ACTIVE) |=>
    $stable(cnt_ff))
    else $error("deselected slave counted a clock");
  chk_phase1_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clock_phase && state_ff == SEI_IDLE && !sck_lead) |=> state_ff == SEI_IDLE)
    else $error("phase 1 transfer began without clock");
  chk_err_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
    (error_irq_enable && (ovr_ff || mode_fault_flag_ff)) |-> rx_err_irq)
    else $error("error request missing");
  chk_tx_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
    tx_irq == (tx_irq_enable && txe_ff))
    else $error("tx request wrong");
  chk_rx_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!module_enable_ff && !error_irq_enable) |-> !rx_err_irq)
    else $error("rx request while disabled");
  chk_rx_full_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    load_rx |=> rxf_ff && rx_data_ff == $past(fifo_out_data))
    else $error("received byte not loaded");
  chk_txe_on_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    (start_xfer && !txe_ff) |=> txe_ff)
    else $error("tx empty not set on shifter load");
  chk_mode_fault_flag_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_fault_flag_ff && !control_write) |=> mode_fault_flag_ff)
    else $error("mode fault cleared without write");
  chk_clear_blocked: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fault_cond && mode_fault_flag_ff) |=> mode_fault_flag_ff)
    else $error("mode fault cleared during fault");

  cov_master_fault: cover property (@(posedge core_clk) disable iff (sys_rst) master_fault);
  cov_phase1_start: cover property (@(posedge core_clk) disable iff (sys_rst)
    start_xfer && clock_phase);
  cov_slave_fault: cover property (@(posedge core_clk) disable iff (sys_rst)
    set_mode_fault_flag && !master_select);
  cov_overflow: cover property (@(posedge core_clk) disable iff (sys_rst) ovr_event);
  cov_byte: cover property (@(posedge core_clk) disable iff (sys_rst) load_rx);
endmodule : sei_core
`default_nettype wire

// ---- tb/sei_master_model.sv ----
// Far-side serial master model: select, clock and data toward the block
`timescale 1ns/1ns
`default_nettype none
module sei_master_model (
  input wire logic core_clk,
  input wire logic miso_out,
  output logic slave_select_n,
  output logic serial_clock_pin,
  output logic mosi_in
);
  // Clock idles low and stands still between frames
  localparam int HALF = 4;
  // Bits seen on the slave data output, sampled on the capture edge
  logic [7:0] miso_byte;
  initial begin
    miso_byte = 8'h00;
    slave_select_n = 1'b1;
    serial_clock_pin = 1'b0;
    mosi_in = 1'b0;
  end
  task automatic set_select(input logic v);
    @(posedge core_clk);
    slave_select_n <= v;
  endtask : set_select
  // Select then deselect with no clock edges
  task automatic select_only();
    set_select(1'b0);
    repeat (HALF) @(posedge core_clk);
    slave_select_n <= 1'b1;
  endtask : select_only
  // One whole byte, MSB first, select toggled around it
  task automatic xfer(input logic [7:0] b, input logic ph);
    set_select(1'b0);
    repeat (HALF) @(posedge core_clk);
    for (int i = 7; i >= 0; i--) begin
      if (!ph) mosi_in <= b[i];
      repeat (HALF) @(posedge core_clk);
      serial_clock_pin <= 1'b1;
      if (!ph) miso_byte <= {miso_byte[6:0], miso_out};
      if (ph) mosi_in <= b[i];
      repeat (HALF) @(posedge core_clk);
      serial_clock_pin <= 1'b0;
      if (ph) miso_byte <= {miso_byte[6:0], miso_out};
    end
    repeat (HALF) @(posedge core_clk);
    slave_select_n <= 1'b1;
    // Released data line must not keep its last value
    mosi_in <= ~mosi_in;
  endtask : xfer
endmodule : sei_master_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the serial error and interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [5:0] P_SET = 6'h20;
  localparam logic [5:0] P_CLR = 6'h10;
  localparam logic [5:0] P_SR = 6'h08;
  localparam logic [5:0] P_CW = 6'h04;
  localparam logic [5:0] P_DR = 6'h02;
  localparam logic [5:0] P_DW = 6'h01;
  logic core_clk, sys_rst, master_select, clock_phase, clock_polarity;
  logic mode_fault_enable, error_irq_enable, tx_irq_enable, rx_irq_enable;
  logic module_enable_set, module_enable_clr, status_read, control_write, data_read, data_write;
  logic slave_select_n, serial_clock_pin, mosi_in, miso_out, miso_oe, port_owned, module_enable;
  logic overflow_flag, mode_fault_flag, receiver_full_flag, transmitter_empty_flag;
  logic tx_irq, rx_err_irq;
  logic [5:0] pls;
  logic [7:0] tx_data, rx_data;
  logic [3:0] bit_count;
  int n_mismatch = 0;
  int n_tests = 0;
  // Software strobes travel as one vector so a pulse is one task
  assign {module_enable_set, module_enable_clr, status_read} = pls[5:3];
  assign {control_write, data_read, data_write} = pls[2:0];
  sei_core DUT (.core_clk, .sys_rst, .module_enable_set, .module_enable_clr, .master_select,
    .clock_phase, .clock_polarity, .mode_fault_enable, .error_irq_enable, .tx_irq_enable,
    .rx_irq_enable, .status_read, .control_write, .data_read, .data_write, .tx_data,
    .slave_select_n, .serial_clock_pin, .mosi_in, .miso_out, .miso_oe, .port_owned,
    .module_enable, .overflow_flag, .mode_fault_flag, .receiver_full_flag,
    .transmitter_empty_flag, .rx_data, .tx_irq, .rx_err_irq, .bit_count);
  sei_master_model MDL (.core_clk, .miso_out, .slave_select_n, .serial_clock_pin, .mosi_in);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic pulse(input logic [5:0] p);
    @(posedge core_clk);
    pls <= p;
    @(posedge core_clk);
    pls <= 6'h00;
  endtask : pulse
  // Flags land one or two edges after their cause
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic wait_rx();
    int k;
    k = 0;
    while (receiver_full_flag !== 1'b1 && k < 60) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (receiver_full_flag !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask : wait_rx
  task automatic t_reset();
    cmp_bit(transmitter_empty_flag, 1'b1);
    cmp_bit(miso_oe, 1'b0);
    cmp_bit(mode_fault_flag, 1'b0);
  endtask : t_reset
  task automatic t_receive();
    @(posedge core_clk);
    rx_irq_enable <= 1'b1;
    tx_irq_enable <= 1'b1;
    tx_data <= 8'h5a;
    pulse(P_SET);
    pulse(P_DW);
    settle();
    cmp_bit(tx_irq, 1'b0);
    MDL.xfer(8'ha5, 1'b0);
    wait_rx();
    settle();
    cmp_byte(rx_data, 8'ha5);
    cmp_bit(rx_err_irq, 1'b1);
    cmp_bit(tx_irq, 1'b1);
    cmp_byte(MDL.miso_byte, 8'h5a);
    cmp_bit(miso_oe, 1'b0);
    MDL.xfer(8'h3c, 1'b0);
    settle();
    cmp_bit(overflow_flag, 1'b1);
    cmp_byte(rx_data, 8'ha5);
    pulse(P_CLR);
    settle();
    cmp_bit(rx_err_irq, 1'b0);
    pulse(P_SR);
    pulse(P_DR);
    settle();
    cmp_bit(overflow_flag, 1'b0);
    cmp_bit(receiver_full_flag, 1'b0);
    pulse(P_SR);
    settle();
    cmp_bit(overflow_flag, 1'b0);
  endtask : t_receive
  task automatic t_slave_fault();
    @(posedge core_clk);
    clock_phase <= 1'b1;
    mode_fault_enable <= 1'b1;
    error_irq_enable <= 1'b1;
    pulse(P_SET);
    MDL.select_only();
    settle();
    cmp_bit(mode_fault_flag, 1'b0);
    @(posedge core_clk);
    clock_phase <= 1'b0;
    MDL.select_only();
    settle();
    cmp_bit(mode_fault_flag, 1'b1);
    cmp_bit(rx_err_irq, 1'b1);
    cmp_bit(module_enable, 1'b1);
    @(posedge core_clk);
    mode_fault_enable <= 1'b0;
    settle();
    cmp_bit(mode_fault_flag, 1'b1);
    pulse(P_SR);
    pulse(P_CW);
    MDL.select_only();
    settle();
    cmp_bit(mode_fault_flag, 1'b0);
    @(posedge core_clk);
    clock_phase <= 1'b1;
    mode_fault_enable <= 1'b1;
    tx_data <= 8'h96;
    pulse(P_CLR);
    pulse(P_SET);
    pulse(P_DW);
    MDL.xfer(8'hc3, 1'b1);
    wait_rx();
    settle();
    cmp_byte(rx_data, 8'hc3);
    cmp_byte(MDL.miso_byte, 8'h96);
    cmp_bit(mode_fault_flag, 1'b0);
  endtask : t_slave_fault
  task automatic t_master_fault();
    @(posedge core_clk);
    master_select <= 1'b1;
    mode_fault_enable <= 1'b1;
    pulse(P_SET);
    pulse(P_DW);
    settle();
    cmp_bit(port_owned, 1'b1);
    cmp_bit(transmitter_empty_flag, 1'b0);
    MDL.set_select(1'b0);
    settle();
    cmp_bit(mode_fault_flag, 1'b1);
    cmp_bit(module_enable, 1'b0);
    cmp_bit(port_owned, 1'b0);
    cmp_bit(transmitter_empty_flag, 1'b1);
    cmp_byte({4'h0, bit_count}, 8'h00);
    cmp_bit(rx_err_irq, 1'b1);
    pulse(P_SR);
    pulse(P_CW);
    settle();
    cmp_bit(mode_fault_flag, 1'b1);
    MDL.set_select(1'b1);
    pulse(P_SR);
    pulse(P_CW);
    settle();
    cmp_bit(mode_fault_flag, 1'b0);
  endtask : t_master_fault
  initial begin
    sys_rst = 1'b1;
    pls = 6'h00;
    master_select = 1'b0;
    clock_phase = 1'b0;
    clock_polarity = 1'b0;
    mode_fault_enable = 1'b0;
    error_irq_enable = 1'b0;
    tx_irq_enable = 1'b0;
    rx_irq_enable = 1'b0;
    tx_data = 8'h00;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    settle();
    t_reset();
    t_receive();
    t_slave_fault();
    t_master_fault();
    conclude();
  end
endmodule : tb
`default_nettype wire
